//--- rtl/ubc_params.svh
// Register offsets, field positions, reset values and timing constants
`ifndef UBC_PARAMS_SVH
`define UBC_PARAMS_SVH

// ==========================================================================
// Register word indexes (byte address bits 5:2 on Wishbone)
`define UBC_OFS_BDH        4'h0
`define UBC_OFS_BDL        4'h1
`define UBC_OFS_CTL1       4'h2
`define UBC_OFS_CTL2       4'h3
`define UBC_OFS_STAT       4'h4
`define UBC_OFS_DATA       4'h5
`define UBC_OFS_RSV6       4'h6
`define UBC_OFS_RSV7       4'h7
`define UBC_ADDR_LSB       2
`define UBC_ADDR_MSB       5

// ==========================================================================
// Reset values
`define UBC_BDH_RST        8'h00
`define UBC_BDL_RST        8'h04
`define UBC_CTL_RST        8'h00

// ==========================================================================
// High divisor, control one and control two field positions
`define UBC_BDH_BRK_IE     7
`define UBC_BDH_EDGE_IE    6
`define UBC_BDH_SBR_MSB    4
`define UBC_C1_LOOP        7
`define UBC_C1_FRZ         6
`define UBC_C1_SRC         5
`define UBC_C1_NINE        4
`define UBC_C1_ROUSE       3
`define UBC_C1_IDLE_STOP   2
`define UBC_C1_PAR_ON      1
`define UBC_C1_PAR_ODD     0
`define UBC_C2_TX_ON       3
`define UBC_C2_RX_ON       2

// ==========================================================================
// Status fields
`define UBC_ST_BRK         0
`define UBC_ST_EDGE        1
`define UBC_ST_GEN_RUN     2
`define UBC_ST_LOOP_ACT    3
`define UBC_ST_SINGLE      4
`define UBC_ST_RXPIN_GP    5

// ==========================================================================
// Baud generator
`define UBC_DIV_W          13
`define UBC_OVERSAMPLE     5'h10
`define UBC_DIV_ZERO       13'h0000
`define UBC_DIV_ONE        13'h0001

`endif

//--- rtl/ubc_pkg.sv
// Types shared by the configuration block
package ubc_pkg;
  typedef logic [12:0] ubc_div_t;
  typedef enum logic [2:0] {
    UBC_RT_NORMAL = 3'b001,
    UBC_RT_LOOP   = 3'b010,
    UBC_RT_SINGLE = 3'b100
  } ubc_route_e;
endpackage

//--- rtl/ubc_baud_gen.sv
// Modulo baud divider producing the 16x oversample tick and the bit tick
`timescale 1ns/100ps
`include "ubc_params.svh"

module ubc_baud_gen (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // Control
  input  wire logic            run,
  input  ubc_pkg::ubc_div_t    divisor,
  // Ticks
  output logic                 os_tick,
  output logic                 bit_tick
);

  ubc_pkg::ubc_div_t cnt_q;
  logic [3:0]        os_q;

  // ==========================================================================
  // Divider: one tick every divisor clocks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= `UBC_DIV_ZERO;
      os_tick <= 1'b0;
    end else if (!run) begin
      cnt_q   <= `UBC_DIV_ZERO;   // Held at zero so a restart begins a fresh period
      os_tick <= 1'b0;
    end else if (cnt_q >= divisor - `UBC_DIV_ONE) begin
      cnt_q   <= `UBC_DIV_ZERO;
      os_tick <= 1'b1;
    end else begin
      cnt_q   <= cnt_q + `UBC_DIV_ONE;
      os_tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Sixteen oversample ticks make one bit time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      os_q     <= 4'h0;
      bit_tick <= 1'b0;
    end else if (!run) begin
      os_q     <= 4'h0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (os_tick) begin
        os_q <= os_q + 4'h1;
        if (os_q == 4'(`UBC_OVERSAMPLE - 5'h01))
          bit_tick <= 1'b1;
      end
    end
  end

endmodule // ubc_baud_gen

//--- rtl/ubc_cfg.sv
// Baud divisor and first control register of the asynchronous serial unit
// How it works
// - Eight byte-wide registers: baud, options, status and data slots.
// - High divisor byte buffers; working divisor updates on low byte write.
// - Low byte resets non-zero; generator waits for first tx or rx enable.
// - Divisor zero stops the baud generator completely.
// - Break flag requests interrupt only when its enable bit is set.
// - Receive edge flag requests interrupt only when its enable bit set.
// - Loopback routes transmitter into receiver; receive pin unused.
// - Source bit ignored without loopback; zero means internal loop.
// - Loopback with source one: single wire on the output pin.
// - Freeze bit stops unit clocks while processor waits.
// - Character length bit chooses eight or nine data bits.
// - Rouse bit selects idle-line or address-mark wakeup.
// - Idle count starts after start bit or after stop bit.
// - Parity enable: generate and check, MSB is parity bit.
// - Odd select gives odd total ones, else even.
// - Transmitter drives output pin while tx_on, in single wire only while tx_dir_out, and after it drops until the frame in flight finishes.
// - Receive pin returns to port use when off or looped.
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "ubc_params.svh"

module ubc_cfg (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // System
  input  wire logic        cpu_wait,
  // Serial pins
  input  wire logic        serial_in_pin,
  input  wire logic        serial_out_pin_i,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  output logic             serial_in_gp,
  // Link to transmitter and receiver
  input  wire logic        tx_serial,
  input  wire logic        tx_busy,
  input  wire logic        tx_dir_out,
  input  wire logic        break_detect_flag,
  input  wire logic        rx_active_edge_flag,
  input  wire logic [7:0]  rx_data,
  output logic             rx_serial,
  output logic             tx_on,
  output logic             rx_on,
  output logic             unit_clk_en,
  output logic             os_tick,
  output logic             bit_tick,
  output logic             nine_bit_char,
  output logic             rouse_addr_mark,
  output logic             idle_count_after_stop,
  output logic             parity_on,
  output logic             parity_odd,
  output logic             break_irq,
  output logic             edge_irq,
  output logic [7:0]       tx_data,
  output logic             tx_data_wr
);

  // ==========================================================================
  // Registers and internal signals
  logic [7:0]         bdh_buf_q;
  logic [7:0]         bdh_work_q;
  logic [7:0]         bdl_q;
  logic [7:0]         ctl1_q;
  logic [7:0]         ctl2_q;
  logic               gen_armed_q;
  logic               rxpin_s1_q;
  logic               rxpin_s2_q;
  logic               txpin_s1_q;
  logic               txpin_s2_q;
  logic               tx_hold_q;
  logic               drive_en;
  logic               access;
  logic               wr_en;
  logic [3:0]         word;
  logic [7:0]         rdata;
  logic [7:0]         status;
  logic               gen_run;
  logic               os_raw;
  logic               bit_raw;
  ubc_pkg::ubc_div_t  divisor;
  ubc_pkg::ubc_route_e route;

  // ==========================================================================
  // Helpers
  function automatic logic sel_hit(input logic [3:0] s, input logic w);
    sel_hit = w & s[0];
  endfunction

  // One write strobe per register slot
  function automatic logic wr_hit(input logic en, input logic [3:0] w,
                                  input logic [3:0] ofs);
    wr_hit = en & (w == ofs);
  endfunction

  function automatic ubc_pkg::ubc_route_e route_of(input logic [7:0] c1);
    if (!c1[`UBC_C1_LOOP])
      route_of = ubc_pkg::UBC_RT_NORMAL;
    else if (c1[`UBC_C1_SRC])
      route_of = ubc_pkg::UBC_RT_SINGLE;
    else
      route_of = ubc_pkg::UBC_RT_LOOP;
  endfunction

  // ==========================================================================
  // Bus decode: single-cycle classic handshake, ack one cycle after request
  // Ack masks the request, so a strobe held high is not taken twice in a row
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign word   = wb_adr_i[`UBC_ADDR_MSB:`UBC_ADDR_LSB];
  assign wr_en  = access & sel_hit(wb_sel_i, wb_we_i);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= access;
  end

  // ==========================================================================
  // Baud divisor: high byte buffered until low byte write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      bdh_buf_q <= `UBC_BDH_RST;
    else if (wr_hit(wr_en, word, `UBC_OFS_BDH))
      bdh_buf_q <= wb_dat_i[7:0];
  end

  // Both halves change on the same edge, so the divider never runs on a
  // mix of an old high half and a new low half
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bdh_work_q <= `UBC_BDH_RST;
      bdl_q      <= `UBC_BDL_RST;
    end else if (wr_hit(wr_en, word, `UBC_OFS_BDL)) begin
      bdl_q      <= wb_dat_i[7:0];
      bdh_work_q <= bdh_buf_q;
    end
  end

  assign divisor = {bdh_work_q[`UBC_BDH_SBR_MSB:0], bdl_q};

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      ctl1_q <= `UBC_CTL_RST;
    else if (wr_hit(wr_en, word, `UBC_OFS_CTL1))
      ctl1_q <= wb_dat_i[7:0];
  end

  // Only the two enables act here; the other bits are kept for software
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      ctl2_q <= `UBC_CTL_RST;
    else if (wr_hit(wr_en, word, `UBC_OFS_CTL2))
      ctl2_q <= wb_dat_i[7:0];
  end

  // Generator stays idle after reset until an enable is first written to one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      gen_armed_q <= 1'b0;
    else if (wr_hit(wr_en, word, `UBC_OFS_CTL2) &&
             (wb_dat_i[`UBC_C2_TX_ON] || wb_dat_i[`UBC_C2_RX_ON]))
      gen_armed_q <= 1'b1;
  end

  assign gen_run = gen_armed_q & (divisor != `UBC_DIV_ZERO)
                 & ~(cpu_wait & ctl1_q[`UBC_C1_FRZ]);

  ubc_baud_gen u_baud (
    .clk      (clk),
    .nrst     (nrst),
    .run      (gen_run),
    .divisor  (divisor),
    .os_tick  (os_raw),
    .bit_tick (bit_raw)
  );

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxpin_s1_q <= 1'b1;
      rxpin_s2_q <= 1'b1;
      txpin_s1_q <= 1'b1;
      txpin_s2_q <= 1'b1;
    end else begin
      rxpin_s1_q <= serial_in_pin;
      rxpin_s2_q <= rxpin_s1_q;
      txpin_s1_q <= serial_out_pin_i;
      txpin_s2_q <= txpin_s1_q;
    end
  end

  assign route = route_of(ctl1_q);

  // Pin keeps driving until a frame in flight finishes after tx_on drops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      tx_hold_q <= 1'b0;
    else
      tx_hold_q <= ctl2_q[`UBC_C2_TX_ON] | tx_busy;
  end

  // ==========================================================================
  // Routing outputs, all registered
  // In single-wire receive the pin is released, and its data copy rests high too
  assign drive_en = tx_hold_q & ((route != ubc_pkg::UBC_RT_SINGLE) | tx_dir_out);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      serial_out_pin_o <= 1'b1;
    else
      serial_out_pin_o <= drive_en ? tx_serial : 1'b1;
  end

  // Receive pin goes back to the port whenever the receiver cannot use it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      serial_in_gp <= 1'b1;
    else
      serial_in_gp <= ~ctl2_q[`UBC_C2_RX_ON] | ctl1_q[`UBC_C1_LOOP];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_serial         <= 1'b1;
      serial_out_pin_oe <= 1'b0;
    end else begin
      unique case (route)
        ubc_pkg::UBC_RT_NORMAL: begin
          rx_serial         <= rxpin_s2_q;
          serial_out_pin_oe <= tx_hold_q;
        end
        ubc_pkg::UBC_RT_LOOP: begin
          rx_serial         <= tx_serial;
          serial_out_pin_oe <= tx_hold_q;
        end
        ubc_pkg::UBC_RT_SINGLE: begin
          rx_serial         <= tx_hold_q && tx_dir_out ? tx_serial : txpin_s2_q;
          serial_out_pin_oe <= tx_hold_q & tx_dir_out;
        end
      endcase
    end
  end

  // ==========================================================================
  // Configuration and tick outputs toward the shift machinery
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_on                 <= 1'b0;
      rx_on                 <= 1'b0;
      unit_clk_en           <= 1'b1;
      os_tick               <= 1'b0;
      bit_tick              <= 1'b0;
      nine_bit_char         <= 1'b0;
      rouse_addr_mark       <= 1'b0;
      idle_count_after_stop <= 1'b0;
      parity_on             <= 1'b0;
      parity_odd            <= 1'b0;
    end else begin
      tx_on                 <= ctl2_q[`UBC_C2_TX_ON];
      rx_on                 <= ctl2_q[`UBC_C2_RX_ON];
      unit_clk_en           <= ~(cpu_wait & ctl1_q[`UBC_C1_FRZ]);
      os_tick               <= os_raw;
      bit_tick              <= bit_raw;
      nine_bit_char         <= ctl1_q[`UBC_C1_NINE];
      rouse_addr_mark       <= ctl1_q[`UBC_C1_ROUSE];
      idle_count_after_stop <= ctl1_q[`UBC_C1_IDLE_STOP];
      parity_on             <= ctl1_q[`UBC_C1_PAR_ON];
      parity_odd            <= ctl1_q[`UBC_C1_PAR_ON]
                             & ctl1_q[`UBC_C1_PAR_ODD];
    end
  end

  // ==========================================================================
  // Interrupt gating of flags owned by the receiver
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      break_irq <= 1'b0;
      edge_irq  <= 1'b0;
    end else begin
      break_irq <= break_detect_flag & bdh_work_q[`UBC_BDH_BRK_IE];
      edge_irq  <= rx_active_edge_flag & bdh_work_q[`UBC_BDH_EDGE_IE];
    end
  end

  // ==========================================================================
  // Data slot: a write passes the byte on with a one-cycle strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_data    <= 8'h00;
      tx_data_wr <= 1'b0;
    end else begin
      tx_data_wr <= wr_hit(wr_en, word, `UBC_OFS_DATA);
      if (wr_hit(wr_en, word, `UBC_OFS_DATA))
        tx_data <= wb_dat_i[7:0];
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    status = 8'h00;
    status[`UBC_ST_BRK]      = break_detect_flag;
    status[`UBC_ST_EDGE]     = rx_active_edge_flag;
    status[`UBC_ST_GEN_RUN]  = gen_run;
    status[`UBC_ST_LOOP_ACT] = ctl1_q[`UBC_C1_LOOP];
    status[`UBC_ST_SINGLE]   = route == ubc_pkg::UBC_RT_SINGLE;
    status[`UBC_ST_RXPIN_GP] = serial_in_gp;
  end

  always_comb begin
    unique case (word)
      `UBC_OFS_BDH:  rdata = bdh_work_q;
      `UBC_OFS_BDL:  rdata = bdl_q;
      `UBC_OFS_CTL1: rdata = ctl1_q;
      `UBC_OFS_CTL2: rdata = ctl2_q;
      `UBC_OFS_STAT: rdata = status;
      `UBC_OFS_DATA: rdata = rx_data;
      default:       rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      wb_dat_o <= 32'h0000_0000;
    else if (access && !wb_we_i)
      wb_dat_o <= {24'h00_0000, rdata};
  end

endmodule // ubc_cfg

//--- verification/ubc_cfg_chk.sv
// Port checker for the baud and frame configuration block
`timescale 1ns/100ps

module ubc_cfg_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Unit side
  input wire logic        cpu_wait,
  input wire logic        tx_dir_out,
  input wire logic        break_detect_flag,
  input wire logic        rx_active_edge_flag,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe,
  input wire logic        serial_in_gp,
  input wire logic        tx_on,
  input wire logic        rx_on,
  input wire logic        unit_clk_en,
  input wire logic        os_tick,
  input wire logic        bit_tick,
  input wire logic        parity_on,
  input wire logic        parity_odd,
  input wire logic        break_irq,
  input wire logic        edge_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Sequences
  sequence s_bit; bit_tick; endsequence
  sequence s_gap; !bit_tick[*8]; endsequence

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_byte_wide: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data wider than a byte");
  a_brk_gate: assert property (!$past(break_detect_flag) |-> !break_irq)
    else $error("break irq without flag");
  a_edge_gate: assert property (!$past(rx_active_edge_flag) |-> !edge_irq)
    else $error("edge irq without flag");
  a_par_forced: assert property (!parity_on |-> !parity_odd)
    else $error("odd select without parity");
  a_oe_drive: assert property ((tx_on && tx_dir_out)[*2] |-> serial_out_pin_oe)
    else $error("output pin not driven");
  a_gp_off: assert property ((!rx_on)[*2] |-> serial_in_gp)
    else $error("receive pin kept from port");
  a_idle_high: assert property (!serial_out_pin_oe |-> serial_out_pin_o)
    else $error("output pin not idle high");
  a_bit_gap: assert property (s_bit |=> s_gap)
    else $error("bit ticks too close");
  a_frz_quiet: assert property ((!unit_clk_en)[*3] |-> !os_tick)
    else $error("tick while frozen");
  a_frz_cause: assert property ($fell(unit_clk_en) |-> $past(cpu_wait))
    else $error("freeze without wait");
  c_os_tick: cover property (os_tick);
endmodule // ubc_cfg_chk

bind ubc_cfg ubc_cfg_chk ubc_cfg_chk_inst (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .cpu_wait, .tx_dir_out, .break_detect_flag, .rx_active_edge_flag,
  .serial_out_pin_o, .serial_out_pin_oe, .serial_in_gp, .tx_on, .rx_on, .unit_clk_en,
  .os_tick, .bit_tick, .parity_on, .parity_odd, .break_irq, .edge_irq);

//--- verification/ubc_remote.sv
// Remote serial transmitter driving the receive pin
`timescale 1ns/100ps

module ubc_remote #(
  parameter int BIT_CYC = 8
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       send,
  input  wire logic [7:0] byte_in,
  output logic            line
);
  logic [9:0] sh_q;
  logic [3:0] n_q;
  int         c_q;

  // A request while a frame is in flight is dropped, as a busy sender would
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_q <= 10'h3ff;
      n_q  <= 4'h0;
      c_q  <= 0;
    end else if (n_q == 4'h0) begin
      if (send) begin
        sh_q <= {1'b1, byte_in, 1'b0};
        n_q  <= 4'ha;
        c_q  <= 0;
      end
    end else if (c_q == BIT_CYC - 1) begin
      sh_q <= {1'b1, sh_q[9:1]};
      n_q  <= n_q - 4'h1;
      c_q  <= 0;
    end else begin
      c_q <= c_q + 1;
    end
  end
  assign line = sh_q[0];
endmodule // ubc_remote

//--- verification/tb_uart_baud_and_frame_config.sv
// Self-checking bench for the baud and frame configuration block
`timescale 1ns/100ps

`define CHK(nm, e, v) begin total_checks++; if ((v) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, v); end end

module tb_uart_baud_and_frame_config;
  logic clk = 0, nrst = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, cpu_wait = 0;
  logic [5:0]  wb_adr = 6'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000, wb_q;
  logic rem_line, pin_o, pin_oe, gp, tx_serial = 1, tx_dir = 1, brk = 0, edg = 0, send = 0;
  logic rx_serial, tx_on, rx_on, clk_en, os_tick, bit_tick, brk_irq, edge_irq, tx_wr;
  wire  [4:0]  fields;
  logic [7:0]  rx_data = 8'h00, tx_data, r, v, b;
  logic [9:0]  fr;
  logic        t, busy = 0;
  wire         txd;
  int          errors = 0, total_checks = 0, seed = 12875, n, d, wr_pulses = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (tx_wr === 1'b1) wr_pulses++;
  // Output line pulled up while nobody drives it
  assign txd = pin_oe ? pin_o : 1'b1;

  ubc_remote #(.BIT_CYC(8)) ubc_remote_inst (.clk(clk), .nrst(nrst), .send(send),
    .byte_in(b), .line(rem_line));

  ubc_cfg ubc_cfg_inst (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .cpu_wait(cpu_wait), .serial_in_pin(rem_line),
    .serial_out_pin_i(txd), .serial_out_pin_o(pin_o), .serial_out_pin_oe(pin_oe),
    .serial_in_gp(gp), .tx_serial(tx_serial), .tx_busy(busy), .tx_dir_out(tx_dir),
    .break_detect_flag(brk), .rx_active_edge_flag(edg), .rx_data(rx_data),
    .rx_serial(rx_serial), .tx_on(tx_on), .rx_on(rx_on), .unit_clk_en(clk_en),
    .os_tick(os_tick), .bit_tick(bit_tick), .nine_bit_char(fields[4]),
    .rouse_addr_mark(fields[3]), .idle_count_after_stop(fields[2]),
    .parity_on(fields[1]), .parity_odd(fields[0]), .break_irq(brk_irq),
    .edge_irq(edge_irq), .tx_data(tx_data), .tx_data_wr(tx_wr));

  function automatic int exp_gap(input bit bt, input int dv);
    return bt ? 16 * dv : dv;
  endfunction

  function automatic logic [4:0] exp_fields(input logic [7:0] c);
    return {c[4], c[3], c[2], c[1], c[1] & c[0]};
  endfunction

  // Classic cycle: held until ack is sampled, then released for one cycle
  task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] dt,
                    input logic [3:0] s, output logic [7:0] q);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we  <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat <= {24'h00_0000, dt};
    // Only the watchdog ends a wait that never sees ack
    do @(posedge clk);
    while (wb_ack !== 1'b1);
    q = wb_q[7:0];
    wb_cyc <= 0;
    wb_stb <= 0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] dt);
    logic [7:0] q;
    wb(a, 1'b1, dt, 4'h1, q);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    wb(a, 1'b0, 8'h00, 4'h1, q);
  endtask

  task automatic count_os(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(posedge clk);
      cnt += (os_tick !== 1'b0);
    end
  endtask

  task automatic gap(input bit bt, output int g);
    int k;
    k = 0;
    while ((bt ? bit_tick : os_tick) !== 1'b1 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    g = 1;
    while ((bt ? bit_tick : os_tick) !== 1'b1 && g < 9000) begin
      @(posedge clk);
      g++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    tally_and_finish;
  end

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(6'h00, r); `CHK("bdh reset", 8'h00, r);
    rd(6'h04, r); `CHK("bdl reset", 8'h04, r);
    rd(6'h08, r); `CHK("ctl1 reset", 8'h00, r);
    rd(6'h18, r); `CHK("reserved", 8'h00, r);
    count_os(64, n); `CHK("ticks before enable", 0, n);
    wr(6'h00, 8'h01);
    rd(6'h00, r); `CHK("bdh before low", 8'h00, r);
    wr(6'h04, 8'h23);
    rd(6'h00, r); `CHK("bdh after low", 8'h01, r);
    wb(6'h04, 1'b1, 8'h55, 4'h0, r);
    rd(6'h04, r); `CHK("masked write", 8'h23, r);
    // ==========================================================
    // Divider rates, a small random divisor and the largest
    d = 2 + ($unsigned($random(seed)) % 4);
    wr(6'h00, 8'h00);
    wr(6'h04, d[7:0]);
    wr(6'h0c, 8'h0c);
    gap(0, n); `CHK("os gap", exp_gap(0, d), n);
    gap(1, n); `CHK("bit gap", exp_gap(1, d), n);
    wr(6'h00, 8'h1f);
    wr(6'h04, 8'hff);
    gap(0, n); `CHK("os gap max", exp_gap(0, 8191), n);
    wr(6'h00, 8'h00);
    wr(6'h04, 8'h00);
    repeat (4) @(posedge clk);
    count_os(100, n); `CHK("ticks at zero", 0, n);
    for (int i = 0; i < 10; i++) begin
      v = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      wr(6'h08, v);
      rd(6'h08, r); `CHK("ctl1 rw", v, r);
      `CHK("fields", exp_fields(v), fields);
    end
    for (int i = 0; i < 4; i++) begin
      wr(6'h00, {i[1], i[0], 6'h00});
      wr(6'h04, 8'h04);
      brk <= 1;
      edg <= 1;
      repeat (2) @(posedge clk);
      `CHK("break irq", 1'(i[1]), brk_irq);
      `CHK("edge irq", 1'(i[0]), edge_irq);
      brk <= 0;
      edg <= 0;
    end
    // ==========================================================
    // Routing: normal, loop, single wire, receiver off
    // Source bit set without loopback must change nothing
    wr(6'h08, 8'h20);
    b = 8'($random(seed));
    send <= 1;
    @(posedge clk);
    send <= 0;
    repeat (7) @(posedge clk);
    for (int j = 0; j < 10; j++) begin
      fr[j] = rx_serial;
      repeat (8) @(posedge clk);
    end
    `CHK("normal frame", {1'b1, b, 1'b0}, fr);
    `CHK("pin to unit", 1'b0, gp);
    wr(6'h08, 8'h80);
    b = 8'h00;
    send <= 1;
    for (int j = 0; j < 8; j++) begin
      t = 1'($random(seed));
      tx_serial <= t;
      repeat (2) @(posedge clk);
      send <= 0;
      `CHK("loop rx", t, rx_serial);
    end
    `CHK("loop pin free", 1'b1, gp);
    wr(6'h08, 8'ha0);
    for (int j = 0; j < 2; j++) begin
      tx_serial <= j[0];
      repeat (6) @(posedge clk);
      `CHK("single rx", j[0], rx_serial);
      `CHK("single drive", 1'b1, pin_oe);
      `CHK("single pin", j[0], pin_o);
    end
    tx_dir <= 0;
    tx_serial <= 0;
    repeat (6) @(posedge clk);
    `CHK("single listen", 1'b1, rx_serial);
    `CHK("single release", 1'b0, pin_oe);
    tx_dir <= 1;
    wr(6'h08, 8'h00);
    wr(6'h0c, 8'h08);
    repeat (3) @(posedge clk);
    `CHK("rx off pin free", 1'b1, gp);
    busy <= 1;
    wr(6'h0c, 8'h00);
    `CHK("drive while busy", 1'b1, pin_oe);
    busy <= 0;
    repeat (3) @(posedge clk);
    `CHK("pin released", 1'b0, pin_oe);
    cpu_wait <= 1;
    wr(6'h08, 8'h40);
    repeat (3) @(posedge clk);
    `CHK("frozen", 1'b0, clk_en);
    wr(6'h08, 8'h00);
    repeat (3) @(posedge clk);
    `CHK("running in wait", 1'b1, clk_en);
    cpu_wait <= 0;
    rx_data <= 8'($random(seed));
    @(posedge clk);
    rd(6'h14, r); `CHK("data read", rx_data, r);
    v = 8'($random(seed));
    wr(6'h14, v); `CHK("data write", v, tx_data);
    `CHK("data strobe", 1, wr_pulses);
    tally_and_finish;
  end
endmodule // tb_uart_baud_and_frame_config
